// file: shared/spp_pkg.sv
// constants and types shared by the serial port, power and framing block
package spp_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int IDLE_TIMEOUT_S = 40;
  // longest idle time, rounded down to whole cycles
  localparam int DEF_IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;
  localparam int RING_QUAL_NS = 1000;
  // least ring time, rounded up to whole cycles
  localparam int RING_QUAL_CYC = (RING_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int DIV_W = 17;
  localparam int DATA_W = 8;
  localparam int BAUD_SEL_W = 3;
  localparam int BIT_CNT_W = 3;
  localparam int TIMER_W = 32;
  localparam int RING_W = 8;

  localparam int BAUD_300 = 300;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_115200 = 115200;

  localparam logic MARK = 1'b1;
  localparam logic SPACE = 1'b0;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_ONE = 3'h1;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [RING_W-1:0] RING_ZERO = 8'h00;
  localparam logic [RING_W-1:0] RING_ONE = 8'h01;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 32'h1;

  typedef logic [DIV_W-1:0] spp_div_t;
  localparam spp_div_t DIV_ZERO = 17'h0;
  localparam spp_div_t DIV_ONE = 17'h1;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8
  } spp_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
  } spp_rx_state_t;

  typedef enum logic [3:0] {
    PW_SLEEP = 4'h1, PW_AWAKE = 4'h2, PW_ON = 4'h4, PW_BEACON = 4'h8
  } spp_pw_state_t;

  // clock cycles per bit for a baud selection code
  function automatic spp_div_t spp_baud_div(input logic [BAUD_SEL_W-1:0] sel);
    int rate;
    rate = BAUD_9600;
    unique case (sel)
      3'h0: rate = BAUD_300;
      3'h1: rate = BAUD_1200;
      3'h2: rate = BAUD_2400;
      3'h3: rate = BAUD_4800;
      3'h4: rate = BAUD_9600;
      3'h5: rate = BAUD_19200;
      3'h6: rate = BAUD_38400;
      3'h7: rate = BAUD_115200;
    endcase
    return spp_div_t'(CLK_HZ / rate);
  endfunction
endpackage

// file: shared/spp_ser_if.sv
`timescale 1ns/10ps
`default_nettype none
// byte channel between the port controller and one serialiser
interface spp_ser_if;
  spp_pkg::spp_div_t div;
  logic [spp_pkg::DATA_W-1:0] data;
  logic strobe;
  logic hold;
  logic busy;
  logic half;
  logic ferr;
  modport tx_end (input div, input data, input strobe, input hold, output busy, output half);
  modport tx_ctl (output div, output data, output strobe, output hold, input busy, input half);
  modport rx_end (input div, output data, output strobe, output busy, output ferr);
  modport rx_ctl (output div, input data, input strobe, input busy, input ferr);
endinterface
`default_nettype wire

// file: src/spp_rx.sv
`timescale 1ns/10ps
`default_nettype none
// 8N1 receiver sampling mid-bit; line is at logic level, idle high
module spp_rx (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic line,
  spp_ser_if.rx_end bus
);
  import spp_pkg::*;
  spp_rx_state_t state;
  spp_div_t cnt;
  logic [BIT_CNT_W-1:0] bitn;
  logic [DATA_W-1:0] shreg;

  wire at_half = (cnt == spp_div_t'((bus.div >> 1) - DIV_ONE));
  wire at_end = (cnt == spp_div_t'(bus.div - DIV_ONE));
  assign bus.busy = (state != RX_IDLE);

  // a glitch shorter than half a bit is rejected as a false start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= RX_IDLE;
      cnt <= DIV_ZERO;
      bitn <= BIT_ZERO;
      shreg <= DATA_ZERO;
      bus.data <= DATA_ZERO;
      bus.strobe <= 1'b0;
      bus.ferr <= 1'b0;
    end else if (clk_en) begin
      bus.strobe <= 1'b0;
      cnt <= spp_div_t'(cnt + DIV_ONE);
      unique case (state)
        RX_IDLE: begin
          cnt <= DIV_ZERO;
          if (line == SPACE) state <= RX_START;
        end
        RX_START: begin
          if (at_half) begin
            cnt <= DIV_ZERO;
            bitn <= BIT_ZERO;
            state <= (line == SPACE) ? RX_DATA : RX_IDLE;
          end
        end
        RX_DATA: begin
          if (at_end) begin
            cnt <= DIV_ZERO;
            shreg <= {line, shreg[DATA_W-1:1]};
            bitn <= bitn + BIT_ONE;
            if (bitn == LAST_BIT) state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (at_end) begin
            bus.data <= shreg;
            bus.strobe <= 1'b1;
            bus.ferr <= (line == SPACE);
            state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  AST_RX_FRAME_ERR: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && state == RX_STOP && at_end && line == SPACE |=> bus.strobe && bus.ferr)
    else $error("spacing stop bit not flagged");
endmodule
`default_nettype wire

// file: src/spp_top.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - ring input forces telecom operating mode
// - modem enable raised after ring is recognised
// - sync-device select addresses devices, enables printer
// - clock line clocks synchronous transfers with data
// - flow line high sends, low pauses
// - a_txd transmit pin inverted: mark low, space high; b_txd is not inverted
// - frames are start, eight data, stop
// - eight selectable baud rates 300 to 115200
// - power setting or open port keeps powered
// - close after open returns port to sleep
// - input wakes port, 40 s idle shutdown
// - in-band session end shuts port immediately
// - sleeping port wakes on receive activity
// - wake-up character is discarded, not delivered
// - beacon powers up, sends, sleeps at once
module spp_top #(
  parameter int TIMEOUT_CYC = spp_pkg::DEF_IDLE_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ring_in,
  input wire logic telecom_done,
  output logic telecom_mode,
  output logic modem_enable_out,
  input wire logic sync_mode,
  input wire logic printer_mode,
  output logic sync_device_select,
  input wire logic clock_or_flow_in,
  output logic clock_or_flow_out,
  output logic clock_or_flow_oe,
  input wire logic [spp_pkg::BAUD_SEL_W-1:0] a_baud_sel,
  input wire logic a_tx_req,
  input wire logic [spp_pkg::DATA_W-1:0] a_tx_data,
  output logic a_tx_ready,
  output logic a_txd,
  input wire logic port_power_setting,
  input wire logic port_open_call,
  input wire logic port_close_call,
  input wire logic session_end,
  input wire logic [spp_pkg::BAUD_SEL_W-1:0] b_baud_sel,
  input wire logic b_tx_req,
  input wire logic [spp_pkg::DATA_W-1:0] b_tx_data,
  output logic b_tx_ready,
  output logic b_txd,
  input wire logic b_rxd,
  output logic [spp_pkg::DATA_W-1:0] b_rx_data,
  output logic b_rx_valid,
  output logic b_frame_err,
  output logic b_powered
);
  import spp_pkg::*;

  // refuse settings the counters cannot serve, before anything runs
  if (TIMEOUT_CYC < 1) begin : g_bad_timeout
    $error("TIMEOUT_CYC must be at least one cycle");
  end
  if (RING_QUAL_CYC >= (1 << RING_W)) begin : g_bad_ring
    $error("ring qualify count does not fit its counter");
  end

  spp_ser_if a_if();
  spp_ser_if b_if();
  spp_ser_if r_if();

  // ---- multi-function port: ring, modem enable, sync devices ----
  logic [RING_W-1:0] ring_cnt;
  wire ring_qualified = (ring_cnt == RING_W'(RING_QUAL_CYC));

  // ring counter saturates; a short spike never enables the modem
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ring_cnt <= RING_ZERO;
    end else if (clk_en) begin
      if (!ring_in) ring_cnt <= RING_ZERO;
      else if (!ring_qualified) ring_cnt <= ring_cnt + RING_ONE;
    end
  end

  // a new ring wins over a simultaneous telecom_done for telecom_mode; for modem_enable_out only a qualified ring does
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      telecom_mode <= 1'b0;
      modem_enable_out <= 1'b0;
    end else if (clk_en) begin
      if (ring_in) telecom_mode <= 1'b1;
      else if (telecom_done) telecom_mode <= 1'b0;
      if (ring_qualified) modem_enable_out <= 1'b1;
      else if (telecom_done) modem_enable_out <= 1'b0;
    end
  end

  // one-word holding register in front of the inverted transmitter
  logic a_pend;
  logic [DATA_W-1:0] a_pend_data;
  wire a_accept = a_tx_req & a_tx_ready;
  wire a_take = a_pend & ~a_if.busy & ~a_if.hold;
  wire next_a_pend = a_take ? 1'b0 : (a_accept ? 1'b1 : a_pend);

  assign a_if.div = spp_baud_div(a_baud_sel);
  assign a_if.data = a_pend_data;
  assign a_if.strobe = a_pend;
  // sync transfers are clocked by us, so only async output obeys the flow line
  assign a_if.hold = ~sync_mode & ~clock_or_flow_in;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_pend <= 1'b0;
      a_pend_data <= DATA_ZERO;
      a_tx_ready <= 1'b0;
    end else if (clk_en) begin
      a_pend <= next_a_pend;
      if (a_accept) a_pend_data <= a_tx_data;
      a_tx_ready <= ~next_a_pend;
    end
  end

  // clock rises mid-bit so the device samples a settled data line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_device_select <= 1'b0;
      clock_or_flow_out <= 1'b0;
      clock_or_flow_oe <= 1'b0;
    end else if (clk_en) begin
      sync_device_select <= printer_mode | (sync_mode & (a_pend | a_if.busy));
      clock_or_flow_out <= sync_mode & a_if.busy & ~a_if.half;
      clock_or_flow_oe <= sync_mode;
    end
  end

  spp_tx #(.INVERT(1'b1)) u_a_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bus(a_if),
    .line(a_txd)
  );

  // ---- RS-232 port with managed power ----
  spp_pw_state_t pw, next_pw;
  logic open_q;
  logic drop_next;
  logic b_pend;
  logic [DATA_W-1:0] b_pend_data;
  logic [TIMER_W-1:0] timer;

  wire forced = port_power_setting | open_q;
  wire b_accept = b_tx_req & b_tx_ready;
  wire b_take = b_pend & ~b_if.busy & ~b_if.hold;
  wire next_b_pend = b_take ? 1'b0 : (b_accept ? 1'b1 : b_pend);
  wire expired = (pw == PW_AWAKE) & (timer == TIMER_ZERO);
  wire woke = (pw == PW_SLEEP) & (next_pw == PW_AWAKE);

  assign b_if.div = spp_baud_div(b_baud_sel);
  assign b_if.data = b_pend_data;
  assign b_if.strobe = b_pend;
  assign b_if.hold = (pw == PW_SLEEP); // unpowered driver starts no new character
  assign r_if.div = spp_baud_div(b_baud_sel);

  // power state; forced power wins over every other event
  always_comb begin
    next_pw = pw;
    unique case (pw)
      PW_SLEEP: begin
        if (forced) next_pw = PW_ON;
        else if (b_accept) next_pw = PW_BEACON;
        else if (r_if.busy) next_pw = PW_AWAKE;
      end
      PW_AWAKE: begin
        if (forced) next_pw = PW_ON;
        else if (session_end || expired) next_pw = PW_SLEEP;
      end
      PW_ON: begin
        if (!forced) next_pw = PW_SLEEP;
      end
      PW_BEACON: begin
        if (forced) next_pw = PW_ON;
        else if (!b_pend && !b_if.busy) next_pw = PW_SLEEP;
      end
    endcase
  end

  // open call wins over a close in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pw <= PW_SLEEP;
      open_q <= 1'b0;
      b_powered <= 1'b0;
    end else if (clk_en) begin
      pw <= next_pw;
      if (port_open_call) open_q <= 1'b1;
      else if (port_close_call) open_q <= 1'b0;
      b_powered <= (next_pw != PW_SLEEP);
    end
  end

  // idle timer restarts on every character either way
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer <= TIMER_ZERO;
    end else if (clk_en) begin
      if (pw != PW_AWAKE || r_if.strobe || b_take) timer <= TIMER_W'(TIMEOUT_CYC - 1);
      else if (timer != TIMER_ZERO) timer <= timer - TIMER_ONE;
    end
  end

  // a request while asleep is unsolicited and becomes a beacon
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b_pend <= 1'b0;
      b_pend_data <= DATA_ZERO;
      b_tx_ready <= 1'b0;
    end else if (clk_en) begin
      b_pend <= next_b_pend;
      if (b_accept) b_pend_data <= b_tx_data;
      b_tx_ready <= ~next_b_pend & (next_pw != PW_BEACON);
    end
  end

  // the character that woke the port is swallowed; senders pad with sync bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drop_next <= 1'b0;
      b_rx_data <= DATA_ZERO;
      b_rx_valid <= 1'b0;
      b_frame_err <= 1'b0;
    end else if (clk_en) begin
      if (woke) drop_next <= 1'b1;
      else if (r_if.strobe) drop_next <= 1'b0;
      b_rx_valid <= r_if.strobe & ~drop_next;
      b_frame_err <= r_if.strobe & r_if.ferr & ~drop_next;
      if (r_if.strobe) b_rx_data <= r_if.data;
    end
  end

  spp_tx #(.INVERT(1'b0)) u_b_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bus(b_if),
    .line(b_txd)
  );

  spp_rx u_b_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .line(b_rxd),
    .bus(r_if)
  );

  // rule checks; each one watches what this module drives
  AST_TELECOM_ON_RING: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && ring_in |=> telecom_mode)
    else $error("ring did not force telecom mode");
  AST_MODEM_AFTER_RING: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(modem_enable_out) |-> $past(ring_qualified) && telecom_mode)
    else $error("modem enable raised without a recognised ring");
  AST_PRINTER_SELECT: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && printer_mode |=> sync_device_select)
    else $error("printer enable strobe missing");
  AST_SYNC_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    clock_or_flow_out |-> clock_or_flow_oe && $past(a_if.busy))
    else $error("sync clock pulse outside a transfer");
  AST_FLOW_PAUSE: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !sync_mode && !clock_or_flow_in && !a_if.busy |=> !a_if.busy)
    else $error("character started while flow line low");
  AST_FORCED_POWER: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && forced |=> b_powered && pw == PW_ON)
    else $error("forced power not honoured");
  AST_CLOSE_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && pw == PW_ON && !forced |=> pw == PW_SLEEP && !b_powered)
    else $error("port not put to sleep after close");
  AST_TIMEOUT_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && expired && !forced |=> pw == PW_SLEEP)
    else $error("idle timeout did not shut the port");
  AST_SESSION_END: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && pw == PW_AWAKE && session_end && !forced |=> pw == PW_SLEEP && !b_powered)
    else $error("session end did not shut the port");
  AST_WAKE: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && pw == PW_SLEEP && r_if.busy && !forced && !b_accept |=> pw == PW_AWAKE && drop_next)
    else $error("receive activity did not wake the port");
  AST_DROP_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && r_if.strobe && drop_next |=> !b_rx_valid && !drop_next)
    else $error("wake-up character was delivered");
  AST_BEACON_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && pw == PW_BEACON && !b_pend && !b_if.busy && !forced |=> pw == PW_SLEEP)
    else $error("beacon did not return straight to sleep");
  // delivery of later characters, open latch and beacon refusal
  AST_RX_DELIVER: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && r_if.strobe && !drop_next |=> b_rx_valid && b_rx_data == $past(r_if.data))
    else $error("received character not delivered");
  AST_OPEN_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && port_open_call |=> open_q)
    else $error("open call not latched");
  AST_BEACON_REFUSE: assert property (@(posedge clk) disable iff (sys_rst)
    pw == PW_BEACON |-> !b_tx_ready)
    else $error("new byte accepted during a beacon");
endmodule
`default_nettype wire

// file: src/spp_tx.sv
`timescale 1ns/10ps
`default_nettype none
// 8N1 serialiser; INVERT flips the pin level
module spp_tx #(
  parameter bit INVERT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  spp_ser_if.tx_end bus,
  output logic line
);
  import spp_pkg::*;
  spp_tx_state_t state, next_state;
  spp_div_t cnt;
  logic [BIT_CNT_W-1:0] bitn;
  logic [DATA_W-1:0] shreg;
  logic cur_bit;

  // a character starts only between frames, so flow control never cuts one
  wire take = bus.strobe & ~bus.hold & (state == TX_IDLE);
  wire bit_end = (cnt == spp_div_t'(bus.div - DIV_ONE));
  assign bus.busy = (state != TX_IDLE);
  assign bus.half = (cnt < (bus.div >> 1));

  // one start, eight data lsb first, one stop, no parity
  always_comb begin
    next_state = state;
    cur_bit = MARK;
    unique case (state)
      TX_IDLE: begin
        if (take) next_state = TX_START;
      end
      TX_START: begin
        cur_bit = SPACE;
        if (bit_end) next_state = TX_DATA;
      end
      TX_DATA: begin
        cur_bit = shreg[0];
        if (bit_end && bitn == LAST_BIT) next_state = TX_STOP;
      end
      TX_STOP: begin
        if (bit_end) next_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= TX_IDLE;
      cnt <= DIV_ZERO;
      bitn <= BIT_ZERO;
      shreg <= DATA_ZERO;
      line <= MARK ^ INVERT;
    end else if (clk_en) begin
      state <= next_state;
      cnt <= (take || bit_end) ? DIV_ZERO : spp_div_t'(cnt + DIV_ONE);
      if (take) shreg <= bus.data;
      else if (bit_end && state == TX_DATA) shreg <= shreg >> 1;
      if (state != TX_DATA) bitn <= BIT_ZERO;
      else if (bit_end) bitn <= bitn + BIT_ONE;
      line <= cur_bit ^ INVERT;
    end
  end

  AST_TX_START_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && state == TX_START |=> line == (SPACE ^ INVERT))
    else $error("start bit not driven at spacing level");
  AST_TX_NINE_BITS: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && state == TX_DATA && bit_end && bitn == LAST_BIT |=> state == TX_STOP)
    else $error("stop bit does not follow the eighth data bit");
endmodule
`default_nettype wire

// file: test/spp_peer.sv
`timescale 1ns/10ps
`default_nettype none
// rs-232 host beside port b; the line rests at mark (high) between frames
module spp_peer (
  input wire logic clk,
  output logic rxd
);
  initial rxd = 1'b1;
  // one frame, lsb first; stop may be forced low to provoke an error
  task automatic send_byte(input logic [7:0] d, input logic stop, input int div);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      rxd = f[i];
      repeat (div - 1) @(negedge clk);
    end
    @(negedge clk);
    rxd = 1'b1;
  endtask
  // a sync byte goes first, since a sleeping port eats the first one
  task automatic send_packet(input logic [7:0] d, input int div);
    send_byte(8'hBD, 1'b1, div);
    send_byte(d, 1'b1, div);
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import spp_pkg::*;
  localparam int TO_CYC = 2000;
  localparam int DIV7 = CLK_HZ / BAUD_115200;
  logic clk, sys_rst, clk_en, ring_in, telecom_done, sync_mode, printer_mode, flow_drv;
  logic a_tx_req, b_tx_req, port_power_setting, port_open_call, port_close_call, session_end;
  logic [2:0] baud;
  logic [7:0] tx_data, b_rx_data;
  logic telecom_mode, modem_enable_out, sync_device_select, clock_or_flow_out, clock_or_flow_oe;
  logic a_tx_ready, a_txd, b_tx_ready, b_txd, b_rx_valid, b_frame_err, b_powered;
  wire logic b_rxd;
  // the shared wire: whoever enables drives it
  wire logic clock_or_flow_in = clock_or_flow_oe ? clock_or_flow_out : flow_drv;
  int mismatches = 0;
  int cmp_count = 0;
  int got_cnt = 0;
  logic got_ferr;
  int rates[8] = '{BAUD_300, BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200, BAUD_38400, BAUD_115200};

  spp_top #(.TIMEOUT_CYC(TO_CYC)) DUT (.clk, .sys_rst, .clk_en, .ring_in, .telecom_done,
    .telecom_mode, .modem_enable_out, .sync_mode, .printer_mode, .sync_device_select,
    .clock_or_flow_in, .clock_or_flow_out, .clock_or_flow_oe, .a_baud_sel(baud), .a_tx_req,
    .a_tx_data(tx_data), .a_tx_ready, .a_txd, .port_power_setting, .port_open_call, .port_close_call,
    .session_end, .b_baud_sel(baud), .b_tx_req, .b_tx_data(tx_data), .b_tx_ready, .b_txd, .b_rxd,
    .b_rx_data, .b_rx_valid, .b_frame_err, .b_powered);
  spp_peer peer (.clk(clk), .rxd(b_rxd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // delivered bytes are one-cycle pulses, so tally them as they pass
  always @(negedge clk) begin
    if (b_rx_valid === 1'b1) begin
      got_cnt++;
      got_ferr = b_frame_err;
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_count(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic pin(input logic sel);
    return sel ? b_txd : a_txd;
  endfunction
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // hold the request from one negedge to the next, i.e. over the taking edge
  task automatic put_byte(input logic sel, input logic [7:0] d);
    int n;
    n = 0;
    while ((sel ? b_tx_ready : a_tx_ready) !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    tx_data = d;
    if (sel) b_tx_req = 1'b1;
    else a_tx_req = 1'b1;
    @(negedge clk);
    a_tx_req = 1'b0;
    b_tx_req = 1'b0;
  endtask
  // finds the start bit, then samples every bit mid-way; port a is inverted
  task automatic chk_frame(input logic sel, input logic [7:0] d, input int div);
    logic [9:0] f;
    int n;
    f = {1'b1, d, 1'b0} ^ {10{~sel}};
    n = 0;
    while (pin(sel) !== f[0] && n < 500) begin
      @(negedge clk);
      n++;
    end
    repeat (div / 2) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      chk_bit(pin(sel), f[i]);
      if (i < 9) repeat (div) @(negedge clk);
    end
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // start-bit width per rate from 1200 to 115200; a reset cuts each slow frame short to save time
  task automatic t_baud;
    int n;
    for (int s = 1; s < 8; s++) begin
      baud = 3'(s);
      put_byte(1'b0, 8'hFF);
      n = 0;
      while (a_txd !== 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      while (a_txd === 1'b1 && n < 70000) begin
        n++;
        @(negedge clk);
      end
      chk_count(n, CLK_HZ / rates[s]);
      do_reset();
    end
  endtask
  task automatic t_ring;
    // a low enable must freeze the ring logic too
    clk_en = 1'b0;
    ring_in = 1'b1;
    repeat (30) @(negedge clk);
    chk_bit(telecom_mode, 1'b0);
    clk_en = 1'b1;
    repeat (RING_QUAL_CYC - 5) @(negedge clk);
    chk_bit(modem_enable_out, 1'b0);
    repeat (10) @(negedge clk);
    chk_bit(modem_enable_out, 1'b1);
    chk_bit(telecom_mode, 1'b1);
    ring_in = 1'b0;
    pulse(telecom_done);
    repeat (2) @(negedge clk);
    chk_bit(telecom_mode, 1'b0);
  endtask
  // flow low holds a byte back; then two bytes queue back to back
  task automatic t_tx_a;
    flow_drv = 1'b0;
    put_byte(1'b0, 8'hA5);
    repeat (300) @(negedge clk);
    chk_bit(a_txd, 1'b0);
    chk_bit(a_tx_ready, 1'b0);
    flow_drv = 1'b1;
    chk_frame(1'b0, 8'hA5, DIV7);
    put_byte(1'b0, 8'h3C);
    put_byte(1'b0, 8'hC3);
    chk_frame(1'b0, 8'h3C, DIV7);
    chk_frame(1'b0, 8'hC3, DIV7);
  endtask
  task automatic t_sync;
    sync_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(clock_or_flow_oe, 1'b1);
    put_byte(1'b0, 8'h81);
    @(negedge clk);
    chk_bit(sync_device_select, 1'b1);
    while (a_txd !== 1'b1) @(negedge clk);
    repeat (DIV7 / 4) @(negedge clk);
    chk_bit(clock_or_flow_out, 1'b0);
    repeat (DIV7 / 2) @(negedge clk);
    chk_bit(clock_or_flow_out, 1'b1);
    repeat (12 * DIV7) @(negedge clk);
    chk_bit(sync_device_select, 1'b0);
    sync_mode = 1'b0;
    printer_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(sync_device_select, 1'b1);
    printer_mode = 1'b0;
  endtask
  task automatic t_rx_power;
    peer.send_packet(8'h3C, DIV7);
    repeat (10) @(negedge clk);
    chk_bit(b_powered, 1'b1);
    chk_count(got_cnt, 1);
    chk_byte(b_rx_data, 8'h3C);
    peer.send_byte(8'h5A, 1'b0, DIV7);
    repeat (10) @(negedge clk);
    chk_count(got_cnt, 2);
    chk_bit(got_ferr, 1'b1);
    repeat (90) @(negedge clk);
    chk_bit(b_powered, 1'b1);
    repeat (TO_CYC + 200) @(negedge clk);
    chk_bit(b_powered, 1'b0);
    peer.send_byte(8'h00, 1'b1, DIV7);
    repeat (10) @(negedge clk);
    chk_count(got_cnt, 2);
    pulse(session_end);
    repeat (2) @(negedge clk);
    chk_bit(b_powered, 1'b0);
  endtask
  task automatic t_hold;
    port_power_setting = 1'b1;
    repeat (TO_CYC + 200) @(negedge clk);
    chk_bit(b_powered, 1'b1);
    port_power_setting = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(b_powered, 1'b0);
    pulse(port_open_call);
    repeat (TO_CYC + 200) @(negedge clk);
    chk_bit(b_powered, 1'b1);
    pulse(port_close_call);
    repeat (3) @(negedge clk);
    chk_bit(b_powered, 1'b0);
  endtask
  // an unsolicited send must not leave the port on for the idle span
  task automatic t_beacon;
    put_byte(1'b1, 8'h96);
    repeat (20) @(negedge clk);
    chk_bit(b_powered, 1'b1);
    chk_bit(b_tx_ready, 1'b0);
    chk_frame(1'b1, 8'h96, DIV7);
    repeat (DIV7) @(negedge clk);
    chk_bit(b_powered, 1'b0);
  endtask

  initial begin
    {ring_in, telecom_done, sync_mode, printer_mode, a_tx_req, b_tx_req} = 6'h00;
    {port_power_setting, port_open_call, port_close_call, session_end} = 4'h0;
    flow_drv = 1'b1;
    baud = 3'h7;
    clk_en = 1'b1;
    tx_data = 8'h00;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(a_txd, 1'b0);
    chk_bit(b_txd, 1'b1);
    chk_bit(b_powered, 1'b0);
    t_baud();
    t_ring();
    t_tx_a();
    t_sync();
    t_rx_power();
    t_hold();
    t_beacon();
    results();
  end
  // the whole run needs roughly 60000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
